// file: logic/wia_aggregator.sv
// Wake interrupt aggregator: sources, cause bitmap, wake status and source identification
`timescale 1ns/1ns
module wia_aggregator #(
    parameter int WT_WIDTH = 32,
    parameter int PC_WIDTH = 16
) (
    // Clocks and reset
    input wire logic ref_clk,
    input wire logic slow_clk,
    input wire logic rst_b,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Digital lines
    input wire logic [20:0] digital_io_line_in,
    output logic [20:0] digital_io_line_oe,
    // Comparator outputs, asynchronous
    input wire logic [1:0] cmp_above,
    // Pulse counter inputs, asynchronous
    input wire logic [1:0] pulse_in,
    // Other peripheral interrupt requests
    input wire logic analogue_irq,
    input wire logic [2:0] timer_irq,
    input wire logic tick_irq,
    input wire logic [1:0] uart_rx_avail,
    input wire logic [1:0] uart_rx_timeout,
    output logic [1:0] uart_rx_read,
    // Interrupt to processor
    output logic irq,
    output logic [3:0] source_identifier,
    output logic [31:0] cause_bitmap
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [31:0] cause;
    logic [31:0] cause_en;
    logic [20:0] io_dir;
    logic [20:0] io_wake_en;
    logic [20:0] io_edge;
    logic [3:0] cmp_cfg;
    logic [3:0] wt_ctrl;
    logic [WT_WIDTH-1:0] wt_period [2];
    logic [PC_WIDTH-1:0] pc_ref [2];
    logic [1:0] pc_ctrl;
    logic [4:0] wake_status;
    logic [31:0] set_vec;
    logic [31:0] clr_vec;
    logic [1:0] wt_pulse;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////
    // Configuration writes

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cause_en <= wia_pkg::RST_ZERO;
            io_dir <= wia_pkg::RST_IO_DIR;
            io_wake_en <= wia_pkg::RST_ZERO[20:0];
            io_edge <= wia_pkg::RST_ZERO[20:0];
            cmp_cfg <= wia_pkg::RST_ZERO[3:0];
            wt_ctrl <= wia_pkg::RST_ZERO[3:0];
            wt_period[0] <= wia_pkg::RST_ZERO[WT_WIDTH-1:0];
            wt_period[1] <= wia_pkg::RST_ZERO[WT_WIDTH-1:0];
            pc_ref[0] <= wia_pkg::RST_ZERO[PC_WIDTH-1:0];
            pc_ref[1] <= wia_pkg::RST_ZERO[PC_WIDTH-1:0];
            pc_ctrl <= wia_pkg::RST_ZERO[1:0];
        end else if (reg_wr) begin
            if (hit(reg_addr, wia_pkg::ADDR_CAUSE_EN)) cause_en <= reg_wdata;
            if (hit(reg_addr, wia_pkg::ADDR_IO_DIR)) io_dir <= reg_wdata[20:0];
            if (hit(reg_addr, wia_pkg::ADDR_IO_WAKE_EN)) io_wake_en <= reg_wdata[20:0];
            if (hit(reg_addr, wia_pkg::ADDR_IO_EDGE)) io_edge <= reg_wdata[20:0];
            if (hit(reg_addr, wia_pkg::ADDR_CMP_CFG)) cmp_cfg <= reg_wdata[3:0];
            if (hit(reg_addr, wia_pkg::ADDR_WT_CTRL)) wt_ctrl <= reg_wdata[3:0];
            if (hit(reg_addr, wia_pkg::ADDR_WT0_PERIOD)) wt_period[0] <= reg_wdata[WT_WIDTH-1:0];
            if (hit(reg_addr, wia_pkg::ADDR_WT1_PERIOD)) wt_period[1] <= reg_wdata[WT_WIDTH-1:0];
            if (hit(reg_addr, wia_pkg::ADDR_PC0_REF)) pc_ref[0] <= reg_wdata[PC_WIDTH-1:0];
            if (hit(reg_addr, wia_pkg::ADDR_PC1_REF)) pc_ref[1] <= reg_wdata[PC_WIDTH-1:0];
            if (hit(reg_addr, wia_pkg::ADDR_PC_CTRL)) pc_ctrl <= reg_wdata[1:0];
        end
    end

    // Output drivers follow direction: set bit means input
    assign digital_io_line_oe = ~io_dir;

    ////////////////////////////////////////////////////////////////////////////
    // Wake timers on the slow clock

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_wt
            logic expired;
            // Start is wt_ctrl[g]; interrupt enable is a separate cause_en bit
            wia_wake_timer #(
                .WIDTH(WT_WIDTH)
            ) u_timer (
                .slow_clk(slow_clk),
                .rst_b(rst_b),
                .start_level(wt_ctrl[g]),
                .period(wt_period[g]),
                .expired(expired)
            );
            wia_sync_pulse u_sync (
                .slow_clk(slow_clk),
                .slow_event(expired),
                .ref_clk(ref_clk),
                .rst_b(rst_b),
                .sys_pulse(wt_pulse[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection

    logic [24:0] pin_meta;
    logic [24:0] pin_sync;
    logic [24:0] pin_prev;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta <= '0;
            pin_sync <= '0;
            pin_prev <= '0;
        end else begin
            pin_meta <= {pulse_in, cmp_above, digital_io_line_in};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    logic [24:0] rise;
    logic [24:0] fall;
    assign rise = pin_sync & ~pin_prev;
    assign fall = ~pin_sync & pin_prev;

    // Line event only when input and wake enabled; edge bit set selects rising
    logic [20:0] io_event;
    assign io_event = io_dir & io_wake_en & ((io_edge & rise[20:0]) | (~io_edge & fall[20:0]));

    // Comparator: cfg[2k] enables, cfg[2k+1] set selects fall below reference
    logic [1:0] cmp_event;
    generate
        for (g = 0; g < 2; g++) begin : gen_cmp
            assign cmp_event[g] = cmp_cfg[2*g] &
                (cmp_cfg[2*g+1] ? fall[21+g] : rise[21+g]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Pulse counters

    logic [PC_WIDTH-1:0] pc_count [2];
    logic [1:0] pc_event;

    // Count restarts after reaching reference so repeated reaches keep interrupting
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_count[0] <= '0;
            pc_count[1] <= '0;
            pc_event <= 2'h0;
        end else begin
            for (int k = 0; k < 2; k++) begin
                pc_event[k] <= 1'b0;
                if (!pc_ctrl[k]) begin
                    pc_count[k] <= '0;
                end else if (rise[23+k]) begin
                    if (pc_count[k] + 1'b1 >= pc_ref[k]) begin
                        pc_count[k] <= '0;
                        pc_event[k] <= 1'b1;
                    end else begin
                        pc_count[k] <= pc_count[k] + 1'b1;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cause bitmap

    always_comb begin
        set_vec = '0;
        set_vec[20:0] = io_event;
        set_vec[wia_pkg::BIT_PC0] = pc_event[0];
        set_vec[wia_pkg::BIT_PC1] = pc_event[1];
        set_vec[wia_pkg::BIT_WT0] = wt_pulse[0];
        set_vec[wia_pkg::BIT_WT1] = wt_pulse[1];
        set_vec[wia_pkg::BIT_CMP0] = cmp_event[0];
        set_vec[wia_pkg::BIT_CMP1] = cmp_event[1];
    end

    assign clr_vec = (reg_wr && hit(reg_addr, wia_pkg::ADDR_CAUSE_CLR)) ? reg_wdata : wia_pkg::RST_ZERO;

    // Sticky; a new event beats a simultaneous clear; only software clears
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cause <= wia_pkg::RST_ZERO;
        end else begin
            cause <= (cause & ~clr_vec) | (set_vec & cause_en);
        end
    end

    // Wake status derives from pending causes, so clearing them clears it
    always_comb begin
        wake_status = '0;
        wake_status[wia_pkg::WS_WT0] = cause[wia_pkg::BIT_WT0];
        wake_status[wia_pkg::WS_WT1] = cause[wia_pkg::BIT_WT1];
        wake_status[wia_pkg::WS_IO] = |cause[20:0];
        wake_status[wia_pkg::WS_CMP0] = cause[wia_pkg::BIT_CMP0];
        wake_status[wia_pkg::WS_CMP1] = cause[wia_pkg::BIT_CMP1];
    end

    ////////////////////////////////////////////////////////////////////////////
    // UART receive interrupts hold until data read

    assign uart_rx_read[0] = reg_rd && hit(reg_addr, wia_pkg::ADDR_UART_RX) && (reg_wdata[0] == 1'b0);
    assign uart_rx_read[1] = reg_rd && hit(reg_addr, wia_pkg::ADDR_UART_RX) && (reg_wdata[0] == 1'b1);

    logic [1:0] uart_req;
    // Level request from the UART; no early clear, it drops when the UART is drained
    assign uart_req = uart_rx_avail | uart_rx_timeout;

    ////////////////////////////////////////////////////////////////////////////
    // Source identification, system controller first

    logic sys_req;
    assign sys_req = |(cause & cause_en);

    wia_pkg::wia_source_t src;
    always_comb begin
        if (sys_req) src = wia_pkg::system_controller_source;
        else if (analogue_irq) src = wia_pkg::analogue_source;
        else if (uart_req[0]) src = wia_pkg::first_uart_source;
        else if (uart_req[1]) src = wia_pkg::second_uart_source;
        else if (timer_irq[0]) src = wia_pkg::timer0_source;
        else if (timer_irq[1]) src = wia_pkg::timer1_source;
        else if (timer_irq[2]) src = wia_pkg::timer2_source;
        else if (tick_irq) src = wia_pkg::tick_timer_source;
        else src = wia_pkg::no_source;
    end

    // Servicer clears the cause before running its handler
    assign irq = sys_req | analogue_irq | (|uart_req) | (|timer_irq) | tick_irq;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            source_identifier <= 4'(wia_pkg::no_source);
            cause_bitmap <= wia_pkg::RST_ZERO;
        end else begin
            source_identifier <= 4'(src);
            cause_bitmap <= cause & cause_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= wia_pkg::RST_ZERO;
        end else if (reg_rd) begin
            case (reg_addr)
                wia_pkg::ADDR_CAUSE: reg_rdata <= cause;
                wia_pkg::ADDR_CAUSE_EN: reg_rdata <= cause_en;
                wia_pkg::ADDR_IO_DIR: reg_rdata <= {11'h000, io_dir};
                wia_pkg::ADDR_IO_WAKE_EN: reg_rdata <= {11'h000, io_wake_en};
                wia_pkg::ADDR_IO_EDGE: reg_rdata <= {11'h000, io_edge};
                wia_pkg::ADDR_CMP_CFG: reg_rdata <= {28'h0000000, cmp_cfg};
                wia_pkg::ADDR_WT_CTRL: reg_rdata <= {28'h0000000, wt_ctrl};
                wia_pkg::ADDR_WT0_PERIOD: reg_rdata <= 32'(wt_period[0]);
                wia_pkg::ADDR_WT1_PERIOD: reg_rdata <= 32'(wt_period[1]);
                wia_pkg::ADDR_PC0_REF: reg_rdata <= 32'(pc_ref[0]);
                wia_pkg::ADDR_PC1_REF: reg_rdata <= 32'(pc_ref[1]);
                wia_pkg::ADDR_PC_CTRL: reg_rdata <= {30'h00000000, pc_ctrl};
                wia_pkg::ADDR_WAKE_STATUS: reg_rdata <= {27'h0000000, wake_status};
                wia_pkg::ADDR_SRC_ID: reg_rdata <= {28'h0000000, 4'(src)};
                default: reg_rdata <= wia_pkg::RST_ZERO;
            endcase
        end else begin
            reg_rdata <= wia_pkg::RST_ZERO;
        end
    end

endmodule : wia_aggregator

// file: logic/wia_pkg.sv
// Package: register map, cause bitmap layout and source identifiers for the wake interrupt aggregator
package wia_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_CAUSE = 8'h00;
    localparam logic [7:0] ADDR_CAUSE_EN = 8'h04;
    localparam logic [7:0] ADDR_CAUSE_CLR = 8'h08;
    localparam logic [7:0] ADDR_IO_DIR = 8'h0c;
    localparam logic [7:0] ADDR_IO_WAKE_EN = 8'h10;
    localparam logic [7:0] ADDR_IO_EDGE = 8'h14;
    localparam logic [7:0] ADDR_CMP_CFG = 8'h18;
    localparam logic [7:0] ADDR_WT_CTRL = 8'h1c;
    localparam logic [7:0] ADDR_WT0_PERIOD = 8'h20;
    localparam logic [7:0] ADDR_WT1_PERIOD = 8'h24;
    localparam logic [7:0] ADDR_PC0_REF = 8'h28;
    localparam logic [7:0] ADDR_PC1_REF = 8'h2c;
    localparam logic [7:0] ADDR_PC_CTRL = 8'h30;
    localparam logic [7:0] ADDR_WAKE_STATUS = 8'h34;
    localparam logic [7:0] ADDR_SRC_ID = 8'h38;
    localparam logic [7:0] ADDR_UART_RX = 8'h3c;

    // Cause bitmap positions
    localparam int DIO_LINES = 21;
    localparam int BIT_PC0 = 22;
    localparam int BIT_PC1 = 23;
    localparam int BIT_WT0 = 26;
    localparam int BIT_WT1 = 27;
    localparam int BIT_CMP0 = 28;
    localparam int BIT_CMP1 = 29;

    // Reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [20:0] RST_IO_DIR = 21'h1f_ffff;

    // Wake status register fields
    localparam int WS_WT0 = 0;
    localparam int WS_WT1 = 1;
    localparam int WS_IO = 2;
    localparam int WS_CMP0 = 3;
    localparam int WS_CMP1 = 4;

    // Slow clock nominal rate
    localparam int SLOW_CLK_KHZ = 32;

    // Interrupt source identifiers
    typedef enum logic [3:0] {
        system_controller_source,
        analogue_source,
        first_uart_source,
        second_uart_source,
        timer0_source,
        timer1_source,
        timer2_source,
        tick_timer_source,
        no_source
    } wia_source_t;

    // UART interrupt kinds
    localparam logic [2:0] UART_INT_RXDATA = 3'h2;
    localparam logic [2:0] UART_INT_TIMEOUT = 3'h6;

endpackage : wia_pkg

// file: logic/wia_sync_pulse.sv
// Toggle-based event crossing from the slow always-on domain into the system clock
`timescale 1ns/1ns
module wia_sync_pulse (
    // Slow side
    input wire logic slow_clk,
    input wire logic slow_event,
    // System side
    input wire logic ref_clk,
    input wire logic rst_b,
    output logic sys_pulse
);

    logic toggle;
    logic meta;
    logic sync;
    logic sync_d;

    // Toggle survives the crossing however slow the source clock is
    always_ff @(posedge slow_clk or negedge rst_b) begin
        if (!rst_b) begin
            toggle <= 1'b0;
        end else if (slow_event) begin
            toggle <= ~toggle;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= 1'b0;
            sync <= 1'b0;
            sync_d <= 1'b0;
        end else begin
            meta <= toggle;
            sync <= meta;
            sync_d <= sync;
        end
    end

    assign sys_pulse = sync ^ sync_d;

endmodule : wia_sync_pulse

// file: logic/wia_wake_timer.sv
// Down-counting wake timer on the slow always-on clock
`timescale 1ns/1ns
module wia_wake_timer #(
    parameter int WIDTH = 32
) (
    // Slow domain
    input wire logic slow_clk,
    input wire logic rst_b,
    // Control, held stable in the system domain
    input wire logic start_level,
    input wire logic [WIDTH-1:0] period,
    // Expiry event
    output logic expired
);

    logic start_meta;
    logic start_sync;
    logic start_d;
    logic running;
    logic [WIDTH-1:0] count;

    always_ff @(posedge slow_clk or negedge rst_b) begin
        if (!rst_b) begin
            start_meta <= 1'b0;
            start_sync <= 1'b0;
            start_d <= 1'b0;
        end else begin
            start_meta <= start_level;
            start_sync <= start_meta;
            start_d <= start_sync;
        end
    end

    // Period captured only on the start edge; later period writes wait for a restart
    always_ff @(posedge slow_clk or negedge rst_b) begin
        if (!rst_b) begin
            running <= 1'b0;
            count <= '0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (start_sync && !start_d) begin
                running <= 1'b1;
                count <= period;
            end else if (!start_sync) begin
                running <= 1'b0;
            end else if (running) begin
                if (count == '0) begin
                    running <= 1'b0;
                    expired <= 1'b1;
                end else begin
                    count <= count - 1'b1;
                end
            end
        end
    end

endmodule : wia_wake_timer

// file: sim/wake_interrupt_aggregator_bench.sv
// Testbench: wake sources, cause bitmap, status and source identification
`timescale 1ns/1ns
module wake_interrupt_aggregator_bench;
    // Shortened slow clock keeps timer runs brief
    localparam int SLOW_HALF_NS = 17;
    logic ref_clk = 1'b0;
    logic slow_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic [20:0] line_in = 21'h0;
    logic [20:0] line_oe;
    logic [1:0] cmp_above = 2'b10;
    logic [1:0] pulse_in = 2'b00;
    logic [5:0] per = 6'h0;
    logic [1:0] uart_rx_avail = 2'b00;
    logic [1:0] uart_rx_read;
    logic irq;
    logic [3:0] source_identifier;
    logic [31:0] cause_bitmap;
    logic [31:0] ws;
    logic [31:0] bm;
    logic [3:0] idt [6] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7};
    int miscompares = 0;
    int tests_run = 0;
    always #4 ref_clk = ~ref_clk;
    always #(SLOW_HALF_NS) slow_clk = ~slow_clk;
    ////////////////////////////////////////////////////////////////
    wia_aggregator #(.WT_WIDTH(32), .PC_WIDTH(16)) dut (
        .ref_clk(ref_clk), .slow_clk(slow_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .digital_io_line_in(line_in),
        .digital_io_line_oe(line_oe), .cmp_above(cmp_above), .pulse_in(pulse_in), .analogue_irq(per[0]),
        .timer_irq(per[4:2]), .tick_irq(per[5]), .uart_rx_avail(uart_rx_avail),
        .uart_rx_timeout({1'b0, per[1]}), .uart_rx_read(uart_rx_read), .irq(irq),
        .source_identifier(source_identifier), .cause_bitmap(cause_bitmap));
    wia_cpu_model cpu (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    // Receiver keeps its request until drained
    always @(posedge ref_clk) begin
        if (uart_rx_read[1] === 1'b1) begin
            uart_rx_avail[1] <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : cyc
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        cpu.rd(a, 32'h0, q);
        check(q, e);
    endtask : rdc
    task automatic wait_bit(input int b);
        int n;
        n = 0;
        while (cause_bitmap[b] !== 1'b1 && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
    endtask : wait_bit
    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    // Whole run is a few hundred cycles
    initial begin
        #200000;
        miscompares++;
        results;
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        cyc(2);
        rdc(wia_pkg::ADDR_IO_DIR, 32'h001f_ffff);
        check(line_oe, 32'h0);
        rdc(wia_pkg::ADDR_CAUSE_EN, 32'h0);
        rdc(8'h40, 32'h0);
        check(source_identifier, 32'h8);
        $display("test reset finished");
        // Line 9 lacks cause enable, line 7 is an output
        cpu.wr(wia_pkg::ADDR_CAUSE_EN, 32'h34df_fdff);
        cpu.wr(wia_pkg::ADDR_IO_DIR, 32'h001f_ff7f);
        cpu.wr(wia_pkg::ADDR_IO_WAKE_EN, 32'h001f_ffff);
        cpu.wr(wia_pkg::ADDR_IO_EDGE, 32'h001f_ffdf);
        cyc(1);
        check(line_oe, 32'h80);
        @(posedge ref_clk) line_in <= 21'h20;
        cyc(6);
        check(cause_bitmap, 32'h0);
        @(posedge ref_clk) line_in <= 21'h288;
        cyc(6);
        check(cause_bitmap, 32'h28);
        check(irq, 32'h1);
        cyc(50);
        check(cause_bitmap, 32'h28);
        cpu.service(ws, bm);
        check(ws, 32'h4);
        check(bm, 32'h28);
        cyc(3);
        check(irq, 32'h0);
        rdc(wia_pkg::ADDR_WAKE_STATUS, 32'h0);
        $display("test lines finished");
        // Comparator 0 on rise, comparator 1 on fall
        cpu.wr(wia_pkg::ADDR_CMP_CFG, 32'hd);
        @(posedge ref_clk) cmp_above <= 2'b11;
        cyc(6);
        check(cause_bitmap, 32'h1000_0000);
        @(posedge ref_clk) cmp_above <= 2'b01;
        cyc(6);
        check(cause_bitmap, 32'h3000_0000);
        cpu.service(ws, bm);
        check(ws, 32'h18);
        $display("test comparators finished");
        cpu.wr(wia_pkg::ADDR_PC0_REF, 32'h3);
        cpu.wr(wia_pkg::ADDR_PC1_REF, 32'h2);
        cpu.wr(wia_pkg::ADDR_PC_CTRL, 32'h3);
        for (int i = 1; i <= 3; i++) begin
            @(posedge ref_clk) pulse_in <= 2'b11;
            cyc(3);
            @(posedge ref_clk) pulse_in <= 2'b00;
            cyc(6);
            check(cause_bitmap, (i >= 2 ? 32'h0080_0000 : 32'h0) | (i == 3 ? 32'h0040_0000 : 32'h0));
        end
        cpu.wr(wia_pkg::ADDR_PC_CTRL, 32'h0);
        cpu.wr(wia_pkg::ADDR_CAUSE_CLR, 32'hffff_ffff);
        $display("test counters finished");
        // Timer 1 runs with its cause disabled
        cpu.wr(wia_pkg::ADDR_WT0_PERIOD, 32'h14);
        cpu.wr(wia_pkg::ADDR_WT1_PERIOD, 32'h14);
        cpu.wr(wia_pkg::ADDR_WT_CTRL, 32'h3);
        cyc(40);
        check(cause_bitmap, 32'h0);
        wait_bit(wia_pkg::BIT_WT0);
        check(cause_bitmap, 32'h0400_0000);
        check(source_identifier, 32'h0);
        cpu.service(ws, bm);
        check(ws, 32'h1);
        cpu.wr(wia_pkg::ADDR_WT_CTRL, 32'h0);
        $display("test timers finished");
        for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk) per <= 6'h1 << i;
            cyc(3);
            check(source_identifier, idt[i]);
            check(irq, 32'h1);
        end
        @(posedge ref_clk) per <= 6'h3f;
        cyc(3);
        check(source_identifier, 32'h1);
        @(posedge ref_clk) per <= 6'h0;
        @(posedge ref_clk) uart_rx_avail[1] <= 1'b1;
        cyc(20);
        check(source_identifier, 32'h3);
        cpu.rd(wia_pkg::ADDR_UART_RX, 32'h1, bm);
        cyc(3);
        check(irq, 32'h0);
        check(source_identifier, 32'h8);
        $display("test sources finished");
        results;
    end
endmodule : wake_interrupt_aggregator_bench

// file: sim/wia_aggregator_assertions.sv
// Checker: port-level assertions for the wake interrupt aggregator
`timescale 1ns/1ns
module wia_aggregator_checker #(
    parameter int WT_WIDTH = 32,
    parameter int PC_WIDTH = 16
) (
    // Clocks and reset
    input wire logic ref_clk,
    input wire logic slow_clk,
    input wire logic rst_b,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Lines and events
    input wire logic [20:0] digital_io_line_in,
    input wire logic [20:0] digital_io_line_oe,
    input wire logic [1:0] cmp_above,
    input wire logic [1:0] pulse_in,
    // Peripheral requests
    input wire logic analogue_irq,
    input wire logic [2:0] timer_irq,
    input wire logic tick_irq,
    input wire logic [1:0] uart_rx_avail,
    input wire logic [1:0] uart_rx_timeout,
    input wire logic [1:0] uart_rx_read,
    // Interrupt
    input wire logic irq,
    input wire logic [3:0] source_identifier,
    input wire logic [31:0] cause_bitmap
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////
    // Shadow of the cause enable, so gating is judged without peeking inside
    logic [31:0] en_shadow;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            en_shadow <= 32'h0;
        end else if (reg_wr && reg_addr == wia_pkg::ADDR_CAUSE_EN) begin
            en_shadow <= reg_wdata;
        end
    end
    sequence s_rd_unmapped;
        reg_rd && reg_addr > wia_pkg::ADDR_UART_RX;
    endsequence
    sequence s_dir_write;
        reg_wr && reg_addr == wia_pkg::ADDR_IO_DIR;
    endsequence
    ////////////////////////////////////////////////////////////////
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data not zero outside read answer");
    unmapped_read_a: assert property (s_rd_unmapped |=> reg_rdata == 32'h0)
        else $error("unmapped read returned data");
    oe_direction_a: assert property (s_dir_write |=> digital_io_line_oe == ~$past(reg_wdata[20:0]))
        else $error("line enables do not follow direction");
    enable_gate_a: assert property ((cause_bitmap & ~$past(en_shadow)) == 32'h0)
        else $error("cause reported without enable");
    irq_hold_a: assert property ((|cause_bitmap) && !$past(reg_wr) |-> irq)
        else $error("irq low with cause pending");
    cause_persist_a: assert property (!$past(reg_wr, 2) |-> ($past(cause_bitmap) & ~cause_bitmap) == 32'h0)
        else $error("cause dropped without software clear");
    reserved_bits_a: assert property (cause_bitmap[31:30] == 2'h0 && cause_bitmap[25:24] == 2'h0 && !cause_bitmap[21])
        else $error("reserved cause bit set");
    uart_irq_a: assert property ((|uart_rx_avail) || (|uart_rx_timeout) |-> irq)
        else $error("uart request not forwarded");
    uart_read_a: assert property (reg_rd && reg_addr == wia_pkg::ADDR_UART_RX |-> uart_rx_read == (reg_wdata[0] ? 2'h2 : 2'h1))
        else $error("uart drain strobe wrong");
    src_none_a: assert property ((source_identifier == 4'h8) == !$past(irq))
        else $error("source identifier disagrees with irq");
endmodule : wia_aggregator_checker

bind wia_aggregator wia_aggregator_checker #(.WT_WIDTH(WT_WIDTH), .PC_WIDTH(PC_WIDTH)) u_chk (
    .ref_clk(ref_clk), .slow_clk(slow_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .digital_io_line_in(digital_io_line_in),
    .digital_io_line_oe(digital_io_line_oe), .cmp_above(cmp_above), .pulse_in(pulse_in),
    .analogue_irq(analogue_irq), .timer_irq(timer_irq), .tick_irq(tick_irq), .uart_rx_avail(uart_rx_avail),
    .uart_rx_timeout(uart_rx_timeout), .uart_rx_read(uart_rx_read), .irq(irq),
    .source_identifier(source_identifier), .cause_bitmap(cause_bitmap));

// file: sim/wia_cpu_model.sv
// Processor model: register port master and interrupt servicing
`timescale 1ns/1ns
module wia_cpu_model (
    // Clock
    input wire logic ref_clk,
    // Register port
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [31:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // Idle bus carries inverted leftovers, never a helpful stale value
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        @(negedge ref_clk);
        q = reg_rdata;
    endtask : rd
    // Status first: clearing the causes wipes it
    task automatic service(output logic [31:0] ws, output logic [31:0] bm);
        rd(wia_pkg::ADDR_WAKE_STATUS, 32'h0, ws);
        rd(wia_pkg::ADDR_CAUSE, 32'h0, bm);
        wr(wia_pkg::ADDR_CAUSE_CLR, bm);
    endtask : service
endmodule : wia_cpu_model
